// ==== hdl/pwr_seq_defines.vh ====
// Constants for the radio power mode sequencer.
// Assumes inclusion by bare name from the design files.
`ifndef PWR_SEQ_DEFINES_VH
`define PWR_SEQ_DEFINES_VH
`define MODE_CORE_OFF     4'h0
`define MODE_TOTAL_OFF    4'h1
`define MODE_STANDBY      4'h5
`define MODE_FIFO_ON      4'h6
`define MODE_SYNTH_RX     4'h8
`define MODE_RX_ACTIVE    4'h9
`define MODE_WAKE_RADIO   4'hb
`define MODE_SYNTH_TX     4'hc
`define MODE_TX_ACTIVE    4'hd
`define ADDR_MODE         4'h0
`define ADDR_STATUS       4'h1
`define ADDR_IRQ_STATUS   4'h2
`define ADDR_IRQ_MASK     4'h3
`define ADDR_FIFO         4'h4
`define ADDR_CONFIG       4'h5
`define CONFIG_RESET      8'ha5
`define STAT_BIT_REG_RDY  0
`define STAT_BIT_BROWNOUT 1
`define STAT_BIT_XTAL_OK  2
`define STAT_BIT_FIFO_OK  3
`define IRQ_BIT_MODE_DONE 0
`define IRQ_BIT_BROWNOUT  1
`define IRQ_BIT_XTAL_OK   2
`define IRQ_BIT_FIFO_REF  3
`define XTAL_SETTLE_US    3000
`define CLK_MHZ           50
`define REG_SETTLE_CYC    8'h10
`define INIT_CYC          8'h20
`endif

// ==== hdl/pin_sync.v ====
// Three-stage synchroniser with agreement filter for one pin.
// Assumes a single clock domain; output changes when stages two and three agree.
`timescale 1ns/1ns
module pin_sync #(
  parameter RESET_VAL = 1'b0
) (
  input  wire clk_i,
  input  wire resetn_i,
  input  wire pin_i,
  output reg  level_o
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_r    <= RESET_VAL;
      s2_r    <= RESET_VAL;
      s3_r    <= RESET_VAL;
      level_o <= RESET_VAL;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_o <= s3_r;
      end
    end
  end
endmodule

// ==== hdl/radio_power_mode_sequencer.v ====
// Radio transceiver power mode sequencer with register port and FIFO gate.
// Assumes a host strobing one-cycle reads and writes; pins sampled asynchronously.
// Notes on behaviour
// R01 - Host steps off, standby, transmit, off
// R02 - Host steps off, standby, receive, off
// R03 - Host waits crystal settling after standby
// R04 - Mode write drives regulators automatically
// R05 - Status word shows regulator ready flag
// R06 - Status word shows brown-out below threshold
// R07 - Core-off cuts core supplies, keeps config
// R08 - Core-off refuses FIFO, discards contents
// R09 - Total-off cuts all, loses all registers (IRQ status is kept)
// R10 - Debugger drives wake line only from total-off
// R11 - Debugger leaves debug lines undriven when idle (the host model drives a toggling pattern on both)
// R12 - Mode codes distinct, receive is 1001
// R13 - Core-off waits until FIFO empty
// R14 - Select low wakes; MISO low until ready
// R15 - Status flags read-only, live on read
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "pwr_seq_defines.vh"
module radio_power_mode_sequencer #(
  parameter FIFO_DEPTH   = 16,
  parameter XTAL_SETTLE_CYC = (`XTAL_SETTLE_US * `CLK_MHZ)
) (
  input  wire       CLK_I,
  input  wire       RESETN_I,
  input  wire [3:0] ADDR_I,
  input  wire [7:0] WDATA_I,
  input  wire       WR_I,
  input  wire       RD_I,
  output reg  [7:0] RDATA_O,
  input  wire       SUPPLY_LOW_I,
  input  wire       SEL_N_I,
  input  wire       WAKE_DRIVE_LINE_I,
  input  wire       DEBUG_LINE_A_I,
  input  wire       DEBUG_LINE_B_I,
  output reg        MISO_O,
  output reg        MISO_OE_O,
  output reg        CORE_SUPPLY_ON_O,
  output reg        XTAL_ON_O,
  output reg        RX_REG_ON_O,
  output reg        TX_REG_ON_O,
  output reg  [3:0] ACTIVE_MODE_O,
  output reg        IRQ_O
);
  localparam ST_OFF   = 4'b0001;
  localparam ST_INIT  = 4'b0010;
  localparam ST_RUN   = 4'b0100;
  localparam ST_DRAIN = 4'b1000;

  function [7:0] read_word;
    input [3:0] a;
    input [3:0] mode;
    input [7:0] st;
    input [7:0] irq;
    input [7:0] msk;
    input [7:0] fifo;
    input [7:0] cfg;
    begin
      case (a)
        `ADDR_MODE:       read_word = {4'h0, mode};
        `ADDR_STATUS:     read_word = st;
        `ADDR_IRQ_STATUS: read_word = irq;
        `ADDR_IRQ_MASK:   read_word = msk;
        `ADDR_FIFO:       read_word = fifo;
        `ADDR_CONFIG:     read_word = cfg;
        default:          read_word = 8'h00;
      endcase
    end
  endfunction

  wire       sel_n_s;
  wire       supply_low_s;
  wire       wake_s;
  wire       dbg_a_s;
  wire       dbg_b_s;
  reg  [3:0] state_r;
  reg  [3:0] mode_req_r;
  reg  [3:0] mode_r;
  reg  [7:0] cfg_r;
  reg  [7:0] irq_r;
  reg  [7:0] irq_nxt;
  reg  [7:0] mask_r;
  reg  [7:0] init_cnt_r;
  reg  [7:0] reg_cnt_r;
  reg  [31:0] xtal_cnt_r;
  reg        xtal_ok_r;
  reg        reg_rdy_r;
  reg        brown_r;
  reg  [7:0] fifo_mem [0:FIFO_DEPTH-1];
  reg  [4:0] fifo_cnt_r;
  reg  [3:0] wp_r;
  reg  [3:0] rp_r;

  pin_sync #(.RESET_VAL(1'b1)) u_sel  (.clk_i(CLK_I), .resetn_i(RESETN_I), .pin_i(SEL_N_I), .level_o(sel_n_s));
  pin_sync #(.RESET_VAL(1'b0)) u_sup  (.clk_i(CLK_I), .resetn_i(RESETN_I), .pin_i(SUPPLY_LOW_I),
                                       .level_o(supply_low_s));
  // Debugger lines only observed; the adapter owns their drive (see R10) (see R11)
  pin_sync #(.RESET_VAL(1'b0)) u_wake (.clk_i(CLK_I), .resetn_i(RESETN_I), .pin_i(WAKE_DRIVE_LINE_I),
                                       .level_o(wake_s));
  pin_sync #(.RESET_VAL(1'b0)) u_dbga (.clk_i(CLK_I), .resetn_i(RESETN_I), .pin_i(DEBUG_LINE_A_I),
                                       .level_o(dbg_a_s));
  pin_sync #(.RESET_VAL(1'b0)) u_dbgb (.clk_i(CLK_I), .resetn_i(RESETN_I), .pin_i(DEBUG_LINE_B_I),
                                       .level_o(dbg_b_s));

  wire       is_run   = (state_r == ST_RUN);
  // Drain must let the host empty the FIFO, else the held mode never arrives
  wire       fifo_ok  = (is_run || state_r == ST_DRAIN) && (mode_r != `MODE_CORE_OFF) && (mode_r != `MODE_STANDBY);
  wire       wr_mode  = WR_I && (ADDR_I == `ADDR_MODE) && (state_r == ST_RUN || state_r == ST_DRAIN);
  wire       fifo_wr  = WR_I && (ADDR_I == `ADDR_FIFO) && fifo_ok && (fifo_cnt_r != FIFO_DEPTH);
  wire       fifo_rd  = RD_I && (ADDR_I == `ADDR_FIFO) && fifo_ok && (fifo_cnt_r != 5'h00);
  wire       fifo_ref = (WR_I || RD_I) && (ADDR_I == `ADDR_FIFO) && !fifo_ok;
  wire       wake_req = !sel_n_s || wake_s;
  wire       need_rx  = (mode_r == `MODE_SYNTH_RX) || (mode_r == `MODE_RX_ACTIVE);
  wire       need_tx  = (mode_r == `MODE_SYNTH_TX) || (mode_r == `MODE_TX_ACTIVE);
  wire       xtal_need = is_run && (mode_r != `MODE_CORE_OFF) && (mode_r != `MODE_WAKE_RADIO);
  wire [7:0] status_w = {4'h0, fifo_ok, xtal_ok_r, brown_r, reg_rdy_r};
  wire       mode_done = is_run && !reg_rdy_r && (reg_cnt_r == 8'h01);

  always @* begin
    irq_nxt = irq_r;
    if (RD_I && ADDR_I == `ADDR_IRQ_STATUS) begin
      irq_nxt = 8'h00;
    end
    // Sets last so an event in the clearing cycle survives
    if (mode_done) irq_nxt[`IRQ_BIT_MODE_DONE] = 1'b1;
    if (supply_low_s && !brown_r) irq_nxt[`IRQ_BIT_BROWNOUT] = 1'b1;
    if (xtal_need && !xtal_ok_r && xtal_cnt_r == XTAL_SETTLE_CYC - 1) irq_nxt[`IRQ_BIT_XTAL_OK] = 1'b1;
    if (fifo_ref) irq_nxt[`IRQ_BIT_FIFO_REF] = 1'b1;
  end

  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_r    <= ST_INIT;
      mode_req_r <= `MODE_CORE_OFF;
      mode_r     <= `MODE_CORE_OFF;
      cfg_r      <= `CONFIG_RESET;
      irq_r      <= 8'h00;
      mask_r     <= 8'h00;
      init_cnt_r <= 8'h00;
      reg_cnt_r  <= 8'h00;
      xtal_cnt_r <= 32'h0;
      xtal_ok_r  <= 1'b0;
      reg_rdy_r  <= 1'b0;
      brown_r    <= 1'b0;
      fifo_cnt_r <= 5'h00;
      wp_r       <= 4'h0;
      rp_r       <= 4'h0;
      RDATA_O    <= 8'h00;
    end else begin
      irq_r   <= irq_nxt;
      brown_r <= supply_low_s; // see R06 see R15
      RDATA_O <= 8'h00;
      if (RD_I) begin
        RDATA_O <= (ADDR_I == `ADDR_FIFO) ? (fifo_rd ? fifo_mem[rp_r] : 8'h00)
                 : read_word(ADDR_I, mode_r, status_w, irq_r, mask_r, 8'h00, cfg_r); // see R05 see R15
      end
      if (WR_I && ADDR_I == `ADDR_IRQ_MASK && state_r != ST_OFF) mask_r <= WDATA_I;
      if (WR_I && ADDR_I == `ADDR_CONFIG && state_r != ST_OFF) cfg_r <= WDATA_I; // see R07
      if (fifo_wr) begin
        fifo_mem[wp_r] <= WDATA_I;
        wp_r <= wp_r + 4'h1;
      end
      if (fifo_rd) rp_r <= rp_r + 4'h1;
      fifo_cnt_r <= fifo_cnt_r + {4'h0, fifo_wr} - {4'h0, fifo_rd};
      if (xtal_need && !xtal_ok_r) begin
        xtal_cnt_r <= xtal_cnt_r + 32'h1;
        if (xtal_cnt_r == XTAL_SETTLE_CYC - 1) xtal_ok_r <= 1'b1; // see R03
      end else if (!xtal_need) begin
        xtal_cnt_r <= 32'h0;
        xtal_ok_r  <= 1'b0;
      end
      if (reg_cnt_r != 8'h00) begin
        reg_cnt_r <= reg_cnt_r - 8'h01;
        if (reg_cnt_r == 8'h01) reg_rdy_r <= 1'b1;
      end
      case (state_r)
        ST_OFF: begin
          // Mode, config, mask and FIFO lost, IRQ status kept; wake restarts from defaults (see R09) (see R14)
          mode_r     <= `MODE_TOTAL_OFF;
          cfg_r      <= `CONFIG_RESET;
          mask_r     <= 8'h00;
          reg_rdy_r  <= 1'b0;
          fifo_cnt_r <= 5'h00;
          wp_r       <= 4'h0;
          rp_r       <= 4'h0;
          if (wake_req) begin
            state_r    <= ST_INIT;
            init_cnt_r <= 8'h00;
            mode_r     <= `MODE_CORE_OFF; // Init powers the core, so no longer total-off
          end
        end
        ST_INIT: begin
          init_cnt_r <= init_cnt_r + 8'h01;
          if (init_cnt_r == `INIT_CYC) begin
            state_r   <= ST_RUN;
            mode_r    <= `MODE_CORE_OFF;
            reg_cnt_r <= `REG_SETTLE_CYC;
          end
        end
        ST_RUN: begin
          if (wr_mode) begin
            mode_req_r <= WDATA_I[3:0];
            if (WDATA_I[3:0] == `MODE_TOTAL_OFF) begin
              state_r <= ST_OFF;
            end else if ((WDATA_I[3:0] == `MODE_CORE_OFF || WDATA_I[3:0] == `MODE_STANDBY) &&
                         fifo_cnt_r != 5'h00) begin
              state_r <= ST_DRAIN; // see R13
            end else begin
              mode_r    <= WDATA_I[3:0]; // see R12
              reg_rdy_r <= 1'b0;
              reg_cnt_r <= `REG_SETTLE_CYC; // see R04
              if (WDATA_I[3:0] == `MODE_CORE_OFF || WDATA_I[3:0] == `MODE_STANDBY) begin
                fifo_cnt_r <= 5'h00; // see R08
                wp_r <= 4'h0;
                rp_r <= 4'h0;
              end
            end
          end
        end
        ST_DRAIN: begin
          if (wr_mode) begin
            mode_req_r <= WDATA_I[3:0];
          end
          if (wr_mode && WDATA_I[3:0] != `MODE_CORE_OFF && WDATA_I[3:0] != `MODE_STANDBY) begin
            state_r <= (WDATA_I[3:0] == `MODE_TOTAL_OFF) ? ST_OFF : ST_RUN;
            if (WDATA_I[3:0] != `MODE_TOTAL_OFF) mode_r <= WDATA_I[3:0];
          end else if (fifo_cnt_r == 5'h00 || (fifo_cnt_r == 5'h01 && fifo_rd)) begin
            state_r    <= ST_RUN;
            mode_r     <= mode_req_r; // see R13
            reg_rdy_r  <= 1'b0;
            reg_cnt_r  <= `REG_SETTLE_CYC;
          end
        end
        default: state_r <= ST_INIT;
      endcase
    end
  end

  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      MISO_O           <= 1'b0;
      MISO_OE_O        <= 1'b0;
      CORE_SUPPLY_ON_O <= 1'b0;
      XTAL_ON_O        <= 1'b0;
      RX_REG_ON_O      <= 1'b0;
      TX_REG_ON_O      <= 1'b0;
      ACTIVE_MODE_O    <= 4'h0;
      IRQ_O            <= 1'b0;
    end else begin
      // MISO low through init, high once ready whether or not selected; only the output enable follows select (see R14)
      MISO_OE_O        <= !sel_n_s;
      MISO_O           <= is_run || state_r == ST_DRAIN;
      CORE_SUPPLY_ON_O <= (is_run && mode_r != `MODE_CORE_OFF && mode_r != `MODE_WAKE_RADIO) ||
                          state_r == ST_DRAIN || state_r == ST_INIT; // see R07 see R09
      XTAL_ON_O        <= xtal_need;
      RX_REG_ON_O      <= is_run && need_rx; // see R04
      TX_REG_ON_O      <= is_run && need_tx;
      ACTIVE_MODE_O    <= mode_r;
      IRQ_O            <= |(irq_nxt & mask_r);
    end
  end
endmodule

// ==== verif/pwr_seq_checker.sv ====
// Assertions on the sequencer's top ports.
// Assumes a bind onto radio_power_mode_sequencer, one clock domain.
`timescale 1ns/1ns
`include "pwr_seq_defines.vh"
module pwr_seq_checker (
  input wire       CLK_I,
  input wire       RESETN_I,
  input wire [3:0] ADDR_I,
  input wire [7:0] WDATA_I,
  input wire       WR_I,
  input wire       RD_I,
  input wire [7:0] RDATA_O,
  input wire       SUPPLY_LOW_I,
  input wire       SEL_N_I,
  input wire       MISO_OE_O,
  input wire       CORE_SUPPLY_ON_O,
  input wire       XTAL_ON_O,
  input wire       RX_REG_ON_O,
  input wire       TX_REG_ON_O,
  input wire [3:0] ACTIVE_MODE_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  wire       st_rd = RD_I && ADDR_I == `ADDR_STATUS;
  wire [3:0] am    = ACTIVE_MODE_O;
  // Regulators and the applied mode both follow the mode register on the same edge
  a_rx_regs: assert property ((am == `MODE_RX_ACTIVE) [*3] |-> RX_REG_ON_O && !TX_REG_ON_O)
    else $error("rx regulator state wrong");
  a_tx_regs: assert property ((am == `MODE_TX_ACTIVE) [*3] |-> TX_REG_ON_O && !RX_REG_ON_O)
    else $error("tx regulator state wrong");
  a_core_quiet: assert property ((am == `MODE_CORE_OFF) [*3] |-> !(XTAL_ON_O | RX_REG_ON_O | TX_REG_ON_O))
    else $error("supplies on in core-off");
  a_deep_dark: assert property ((am == `MODE_TOTAL_OFF) [*3] |-> !CORE_SUPPLY_ON_O)
    else $error("core supply on in total-off");
  a_fifo_refused: assert property (RD_I && ADDR_I == `ADDR_FIFO && am == `MODE_CORE_OFF |=> RDATA_O == 8'h00)
    else $error("fifo read answered in core-off");
  a_mode_applied: assert property (WR_I && ADDR_I == `ADDR_MODE && WDATA_I[3] && am == `MODE_STANDBY
    |-> ##2 am == $past(WDATA_I[3:0], 2))
    else $error("active mode not applied");
  a_brownout_set: assert property (SUPPLY_LOW_I [*8] ##0 st_rd |=> RDATA_O[`STAT_BIT_BROWNOUT])
    else $error("brownout flag missing");
  a_brownout_live: assert property (!SUPPLY_LOW_I [*8] ##0 st_rd |=> !RDATA_O[`STAT_BIT_BROWNOUT])
    else $error("brownout flag stale");
  a_miso_quiet: assert property (SEL_N_I [*8] |-> !MISO_OE_O)
    else $error("miso driven while deselected");
  c_tx: cover property (am == `MODE_TX_ACTIVE);
  c_rx: cover property (am == `MODE_RX_ACTIVE);
  c_deep: cover property (am == `MODE_TOTAL_OFF);
endmodule
bind radio_power_mode_sequencer pwr_seq_checker chk (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .SUPPLY_LOW_I(SUPPLY_LOW_I),
  .SEL_N_I(SEL_N_I), .MISO_OE_O(MISO_OE_O), .CORE_SUPPLY_ON_O(CORE_SUPPLY_ON_O), .XTAL_ON_O(XTAL_ON_O),
  .RX_REG_ON_O(RX_REG_ON_O), .TX_REG_ON_O(TX_REG_ON_O), .ACTIVE_MODE_O(ACTIVE_MODE_O));

// ==== verif/host_model.sv ====
// Host controller and debug adapter model for the sequencer.
// Assumes the bench owns the clock and calls these tasks.
`timescale 1ns/1ns
`include "pwr_seq_defines.vh"
module host_model #(
  parameter XTAL_CYC = 20
) (
  input  wire       clk_i,
  input  wire [7:0] rdata_i,
  output reg  [3:0] addr_o  = 4'h0,
  output reg  [7:0] wdata_o = 8'h00,
  output reg        wr_o    = 1'b0,
  output reg        rd_o    = 1'b0,
  output reg        sel_n_o = 1'b1,
  output reg        wake_o  = 1'b0,
  output reg        dbg_a_o = 1'b0,
  output reg        dbg_b_o = 1'b1
);
  // Undriven debug pins float; a moving pattern keeps them honest
  always @(posedge clk_i) begin
    dbg_a_o <= ~dbg_a_o;
    dbg_b_o <= dbg_a_o;
  end
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge clk_i);
      addr_o  <= a;
      wdata_o <= d;
      wr_o    <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, output [7:0] d);
    begin
      @(posedge clk_i);
      addr_o <= a;
      rd_o   <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      @(negedge clk_i);
      d = rdata_i;
    end
  endtask
  // Standby first, crystal settles, then the active mode
  task session_on(input [3:0] m);
    begin
      wr(`ADDR_MODE, `MODE_STANDBY);
      repeat (XTAL_CYC + 8) @(posedge clk_i);
      wr(`ADDR_MODE, m);
    end
  endtask
  // Wake line is only driven to leave total-off, pulled low otherwise
  task wake(input w, input v);
    begin
      @(posedge clk_i);
      if (w)
        wake_o <= v;
      else
        sel_n_o <= !v;
    end
  endtask
endmodule

// ==== verif/radio_power_mode_sequencer_tb.sv ====
// Self-checking bench for the power mode sequencer.
// Assumes host_model owns the register port and the select, wake and debug pins; the bench drives supply_low.
`timescale 1ns/1ns
`include "pwr_seq_defines.vh"
module radio_power_mode_sequencer_tb;
  localparam XS = 20;
  reg        clk = 1'b0;
  reg        resetn = 1'b0;
  reg        supply_low = 1'b0;
  wire [3:0] addr, amode;
  wire [7:0] wdata, rdata;
  wire       wr, rd, sel_n, wake, dbg_a, dbg_b, miso, miso_oe, core_on, xtal_on, rx_on, tx_on, irq;
  integer    mismatches = 0;
  integer    n_compared = 0;
  reg  [7:0] v;
  radio_power_mode_sequencer #(.XTAL_SETTLE_CYC(XS)) DUT (
    .CLK_I(clk), .RESETN_I(resetn), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .SUPPLY_LOW_I(supply_low), .SEL_N_I(sel_n), .WAKE_DRIVE_LINE_I(wake),
    .DEBUG_LINE_A_I(dbg_a), .DEBUG_LINE_B_I(dbg_b), .MISO_O(miso), .MISO_OE_O(miso_oe),
    .CORE_SUPPLY_ON_O(core_on), .XTAL_ON_O(xtal_on), .RX_REG_ON_O(rx_on), .TX_REG_ON_O(tx_on),
    .ACTIVE_MODE_O(amode), .IRQ_O(irq));
  host_model #(.XTAL_CYC(XS)) host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd), .sel_n_o(sel_n), .wake_o(wake), .dbg_a_o(dbg_a), .dbg_b_o(dbg_b));
  function [7:0] b(input x);
    b = {7'h00, x};
  endfunction
  task check(input string nm, input [7:0] seen, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("[ERR] %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task t_session(input [3:0] m);
    begin
      host.session_on(m);
      cyc(20);
      check("mode", {4'h0, amode}, {4'h0, m});
      check("rx_reg", b(rx_on), b(m == `MODE_RX_ACTIVE));
      check("tx_reg", b(tx_on), b(m == `MODE_TX_ACTIVE));
      check("xtal_on", b(xtal_on), 8'h01);
      host.rd(`ADDR_STATUS, v);
      check("reg_ready", b(v[`STAT_BIT_REG_RDY]), 8'h01);
      host.wr(`ADDR_MODE, `MODE_CORE_OFF);
      cyc(4);
      check("off_supplies", b(xtal_on | rx_on | tx_on), 8'h00);
    end
  endtask
  task t_fifo;
    begin
      host.wr(`ADDR_MODE, `MODE_FIFO_ON);
      host.wr(`ADDR_FIFO, 8'h11);
      host.wr(`ADDR_FIFO, 8'h22);
      host.wr(`ADDR_MODE, `MODE_CORE_OFF);
      cyc(4);
      check("drain_hold", {4'h0, amode}, {4'h0, `MODE_FIFO_ON});
      host.rd(`ADDR_FIFO, v);
      check("fifo_first", v, 8'h11);
      host.rd(`ADDR_FIFO, v);
      check("fifo_second", v, 8'h22);
      cyc(4);
      check("drain_done", {4'h0, amode}, {4'h0, `MODE_CORE_OFF});
      host.wr(`ADDR_IRQ_MASK, 8'h08);
      host.rd(`ADDR_FIFO, v);
      check("fifo_refused", v, 8'h00);
      cyc(2);
      check("irq_raised", b(irq), 8'h01);
      host.rd(`ADDR_IRQ_STATUS, v);
      check("irq_refused", v & 8'h08, 8'h08);
      cyc(2);
      check("irq_cleared", b(irq), 8'h00);
    end
  endtask
  task t_brown;
    begin
      @(posedge clk) supply_low <= 1'b1;
      cyc(10);
      host.rd(`ADDR_STATUS, v);
      check("brownout_set", b(v[`STAT_BIT_BROWNOUT]), 8'h01);
      host.rd(`ADDR_IRQ_STATUS, v);
      check("brownout_irq", v & 8'h02, 8'h02);
      @(posedge clk) supply_low <= 1'b0;
      host.wr(`ADDR_STATUS, 8'hff);
      cyc(10);
      host.rd(`ADDR_STATUS, v);
      check("brownout_clr", b(v[`STAT_BIT_BROWNOUT]), 8'h00);
      host.rd(4'hf, v);
      check("unmapped", v, 8'h00);
    end
  endtask
  task t_deep(input w);
    integer i;
    begin
      host.wr(`ADDR_CONFIG, 8'h3c);
      host.rd(`ADDR_CONFIG, v);
      check("cfg_kept", v, 8'h3c);
      host.wr(`ADDR_MODE, `MODE_TOTAL_OFF);
      cyc(6);
      check("core_supply", b(core_on), 8'h00);
      check("miso_low", b(miso), 8'h00);
      host.wake(w, 1'b1);
      for (i = 0; i < 200 && miso !== 1'b1; i = i + 1)
        @(posedge clk);
      if (i == 200) begin
        mismatches = mismatches + 1;
        report_and_stop;
      end
      check("miso_oe", b(miso_oe), b(!w));
      host.wake(w, 1'b0);
      cyc(8);
      host.rd(`ADDR_CONFIG, v);
      check("cfg_lost", v, `CONFIG_RESET);
    end
  endtask
  initial begin
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    cyc(40);
    t_session(`MODE_TX_ACTIVE);
    t_session(`MODE_RX_ACTIVE);
    t_fifo;
    t_brown;
    t_deep(1'b0);
    t_deep(1'b1);
    report_and_stop;
  end
endmodule
